//--- src/rsc_strap_cfg.sv
// Purpose: Captures boot straps at reset release and holds clock select and clock output controls
// Assumes: Straps are asynchronous pins; clock gating cells and muxes sit outside this block
// Notes:   Memory clock switch hands out two source enables, never both high together
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module rsc_strap_cfg #(
  parameter int VARIANT = 2
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        endian_strap,
  input  wire logic [1:0]  boot_strap,
  input  wire logic        clock_source_strap,
  output logic             strap_captured,
  output logic             endian_field,
  output logic [1:0]       boot_mode,
  output logic             boot_reserved,
  output logic             core_clock_x4,
  output logic             clock_source_square,
  output logic             mem_src_gen_en,
  output logic             mem_src_ext_en,
  output logic             full_clock_out_enable,
  output logic             half_clock_out_enable,
  output logic             half_pin_gpio,
  output logic             osc_div_enable,
  output logic [4:0]       osc_div_ratio
);

  // Only the two variants are decoded; refuse anything else at elaboration
  if (VARIANT != 1 && VARIANT != 2) begin : g_bad_variant
    $error("VARIANT must be 1 or 2");
  end

  localparam logic          IS_V2   = (VARIANT == 2);
  localparam logic [7:0]    GAP_CYC = 8'(rsc_pkg::SWITCH_GAP_CYC);

  rsc_pkg::rsc_state_t st;
  rsc_pkg::rsc_state_t nx;

  logic        bus_req;
  logic        wr_strobe;
  logic [31:0] rd_word;

  // Bus decode; writes land at the edge where the master sees ack
  assign bus_req   = wb_cyc_i && wb_stb_i;
  assign wr_strobe = bus_req && wb_we_i && st.ack && wb_sel_i[0];

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (wb_adr_i)
      rsc_pkg::DEVICE_CONFIG_ADDR: begin
        rd_word[rsc_pkg::MEM_CLOCK_SEL_BIT] = st.mem_sel;
      end
      rsc_pkg::CLOCK_OUT_CTRL_ADDR: begin
        rd_word[rsc_pkg::FULL_EN_BIT]   = st.full_en;
        rd_word[rsc_pkg::HALF_EN_BIT]   = st.half_en;
        rd_word[rsc_pkg::HALF_GPIO_BIT] = st.half_gpio;
      end
      rsc_pkg::OSC_DIVIDER_ADDR: begin
        rd_word[rsc_pkg::OSC_RATIO_LSB +: rsc_pkg::OSC_RATIO_W] = st.osc_ratio;
        rd_word[rsc_pkg::OSC_EN_BIT]                           = st.osc_en;
      end
      rsc_pkg::STRAP_STATUS_ADDR: begin
        rd_word[rsc_pkg::ST_ENDIAN_BIT]         = st.endian;
        rd_word[rsc_pkg::ST_BOOT_LSB +: 2]      = st.boot;
        rd_word[rsc_pkg::ST_CLKSTRAP_BIT]       = st.clk_strap;
        rd_word[rsc_pkg::ST_CAPTURED_BIT]       = st.captured;
        rd_word[rsc_pkg::ST_BOOT_RES_BIT]       = st.boot_res;
        rd_word[rsc_pkg::ST_ENDIAN_RES_BIT]     = st.captured && (st.endian != rsc_pkg::ENDIAN_LITTLE);
        rd_word[rsc_pkg::ST_CLK_RES_BIT]        = IS_V2 && st.captured && !st.clk_strap;
        rd_word[rsc_pkg::ST_ACTIVE_SRC_BIT]     = st.ext_en;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    nx = st;

    // Three-stage strap synchroniser; only stage two reads stage one
    nx.sync1 = {clock_source_strap, boot_strap, endian_strap};
    nx.sync2 = st.sync1;
    nx.sync3 = st.sync2;

    // Capture once after release, once the pipeline holds real pin levels
    if (!st.captured) begin
      if (st.fill_cnt != rsc_pkg::SYNC_FILL) begin
        nx.fill_cnt = st.fill_cnt + 2'h1;
      end else if (st.sync2 == st.sync3) begin
        nx.captured  = 1'b1;
        nx.endian    = st.sync3[0];
        nx.boot      = st.sync3[2:1];
        nx.clk_strap = st.sync3[3];
        nx.boot_res  = (st.sync3[2:1] == rsc_pkg::BOOT_RESERVED);
        nx.core_x4    = !IS_V2 && st.sync3[3];
        nx.square_src = IS_V2 && st.sync3[3];
      end
    end
    // Captured values are never touched again until reset

    // Single-cycle ack, dropped the cycle after it is given
    nx.ack   = bus_req && !st.ack;
    nx.rdata = (bus_req && !st.ack) ? rd_word : 32'h0000_0000;

    // Register writes; low byte lane only here, the oscillator enable in bit 15 is written below
    if (wr_strobe) begin
      unique case (wb_adr_i)
        rsc_pkg::DEVICE_CONFIG_ADDR: begin
          if (IS_V2) begin
            nx.mem_sel = wb_dat_i[rsc_pkg::MEM_CLOCK_SEL_BIT];
          end
        end
        rsc_pkg::CLOCK_OUT_CTRL_ADDR: begin
          nx.full_en   = wb_dat_i[rsc_pkg::FULL_EN_BIT];
          nx.half_en   = wb_dat_i[rsc_pkg::HALF_EN_BIT];
          nx.half_gpio = IS_V2 && wb_dat_i[rsc_pkg::HALF_GPIO_BIT];
        end
        rsc_pkg::OSC_DIVIDER_ADDR: begin
          nx.osc_ratio = wb_dat_i[rsc_pkg::OSC_RATIO_LSB +: rsc_pkg::OSC_RATIO_W];
        end
        default: begin
        end
      endcase
    end
    // Enable bit sits in the second byte lane
    if (bus_req && wb_we_i && st.ack && wb_sel_i[1] && (wb_adr_i == rsc_pkg::OSC_DIVIDER_ADDR)) begin
      nx.osc_en = IS_V2 && wb_dat_i[rsc_pkg::OSC_EN_BIT];
    end

    // Break before make: drop the old source, wait dead time, raise the new
    unique case (st.sw_state)
      rsc_pkg::RSC_SW_IDLE: begin
        if (st.mem_sel != st.ext_en) begin
          nx.gen_en   = 1'b0;
          nx.ext_en   = 1'b0;
          nx.gap_cnt  = GAP_CYC;
          nx.sw_state = rsc_pkg::RSC_SW_GAP;
        end
      end
      rsc_pkg::RSC_SW_GAP: begin
        if (st.gap_cnt == 8'h01) begin
          nx.sw_state = rsc_pkg::RSC_SW_RAISE;
        end
        nx.gap_cnt = st.gap_cnt - 8'h01;
      end
      rsc_pkg::RSC_SW_RAISE: begin
        // Selection sampled late so a second write during the gap still wins
        nx.gen_en   = !st.mem_sel;
        nx.ext_en   = st.mem_sel;
        nx.sw_state = rsc_pkg::RSC_SW_IDLE;
      end
    endcase
  end

  // Single state register; clock enable freezes everything
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st            <= '0;
      st.endian     <= rsc_pkg::ENDIAN_LITTLE;
      st.boot       <= rsc_pkg::BOOT_ROM8;
      st.clk_strap  <= rsc_pkg::CLK_STRAP_DEF;
      st.core_x4    <= !IS_V2;
      st.square_src <= IS_V2;
      st.full_en    <= 1'b1;
      st.half_en    <= 1'b1;
      st.osc_ratio  <= rsc_pkg::OSC_RATIO_RST;
      st.sw_state   <= rsc_pkg::RSC_SW_IDLE;
      st.gen_en     <= 1'b1;
    end else if (clk_en) begin
      st <= nx;
    end
  end

  // Outputs come straight from the state flops
  assign wb_dat_o              = st.rdata;
  assign wb_ack_o              = st.ack;
  assign strap_captured        = st.captured;
  assign endian_field          = st.endian;
  assign boot_mode             = st.boot;
  assign boot_reserved         = st.boot_res;
  assign core_clock_x4         = st.core_x4;
  assign clock_source_square   = st.square_src;
  assign mem_src_gen_en        = st.gen_en;
  assign mem_src_ext_en        = st.ext_en;
  assign full_clock_out_enable = st.full_en;        // Pin only exists on the first variant
  assign half_clock_out_enable = st.half_en;
  assign half_pin_gpio         = st.half_gpio;      // GPIO enable and direction live in the GPIO block
  assign osc_div_enable        = st.osc_en;
  assign osc_div_ratio         = st.osc_ratio;

  // Captured straps come from the synchroniser output at the capture edge
  property p_capture_value;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(st.captured) |-> (st.endian == $past(st.sync3[0])) && (st.boot == $past(st.sync3[2:1]));
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("strap capture value wrong");

  // Once captured, straps never move regardless of pins
  property p_strap_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    st.captured |=> st.captured && $stable(st.endian) && $stable(st.boot) && $stable(st.clk_strap);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("captured strap changed");

  // Reserved boot code flagged exactly when boot pins read 11
  property p_boot_reserved;
    @(posedge ref_clk) disable iff (sys_rst)
    st.captured |-> (st.boot_res == (st.boot == rsc_pkg::BOOT_RESERVED));
  endproperty
  a_boot_reserved: assert property (p_boot_reserved) else $error("boot reserved flag wrong");

  // Clock multiplier follows the clock strap on the first variant only
  property p_clock_mode;
    @(posedge ref_clk) disable iff (sys_rst)
    st.captured |-> (st.core_x4 == (!IS_V2 && st.clk_strap)) && (st.square_src == (IS_V2 && st.clk_strap));
  endproperty
  a_clock_mode: assert property (p_clock_mode) else $error("clock mode decode wrong");

  // Both memory clock sources never enabled together
  property p_no_overlap;
    @(posedge ref_clk) disable iff (sys_rst)
    !(st.gen_en && st.ext_en);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("memory clock sources overlap");

  // A dropped source leaves a dead gap before any source rises
  property p_dead_gap;
    @(posedge ref_clk) disable iff (sys_rst)
    ($fell(st.gen_en) || $fell(st.ext_en)) && clk_en |=> !st.gen_en && !st.ext_en;
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("no dead time on clock switch");

  // A settled switch matches the software selection
  property p_sel_follow;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sw_state == rsc_pkg::RSC_SW_IDLE) && $stable(st.mem_sel) && (st.gen_en || st.ext_en) |-> (st.ext_en == st.mem_sel);
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("memory clock source mismatch");

  // Half-rate enable takes the written bit
  property p_half_write;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_strobe && clk_en && (wb_adr_i == rsc_pkg::CLOCK_OUT_CTRL_ADDR) |=> (st.half_en == $past(wb_dat_i[rsc_pkg::HALF_EN_BIT]));
  endproperty
  a_half_write: assert property (p_half_write) else $error("half clock enable not written");

  // First variant never changes the memory clock select
  property p_v1_config;
    @(posedge ref_clk) disable iff (sys_rst)
    !IS_V2 |-> !st.mem_sel;
  endproperty
  a_v1_config: assert property (p_v1_config) else $error("config written on first variant");

  // Ack lasts one cycle
  property p_ack_pulse;
    @(posedge ref_clk) disable iff (sys_rst)
    st.ack && clk_en |=> !st.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  // A fresh request is answered on the very next edge
  property p_ack_answer;
    @(posedge ref_clk) disable iff (sys_rst)
    bus_req && !st.ack && clk_en |=> st.ack;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

  // Read data is zero whenever ack is low, so a stale word cannot leak
  property p_rdata_zero;
    @(posedge ref_clk) disable iff (sys_rst)
    !st.ack |-> (st.rdata == 32'h0000_0000);
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("read data outside ack");

  // Synchroniser stages shift one place per enabled edge
  property p_sync_chain;
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en |=> (st.sync2 == $past(st.sync1)) && (st.sync3 == $past(st.sync2));
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("strap synchroniser broken");

  // Fill counter steps once per enabled edge until the pipeline is full
  property p_fill_count;
    @(posedge ref_clk) disable iff (sys_rst)
    !st.captured && (st.fill_cnt != rsc_pkg::SYNC_FILL) && clk_en |=> (st.fill_cnt == $past(st.fill_cnt) + 2'h1);
  endproperty
  a_fill_count: assert property (p_fill_count) else $error("fill counter stalled");

  // No capture before the pipeline is full and stages two and three agree
  property p_capture_wait;
    @(posedge ref_clk) disable iff (sys_rst)
    !st.captured && !(clk_en && (st.fill_cnt == rsc_pkg::SYNC_FILL) && (st.sync2 == st.sync3)) |=> !st.captured;
  endproperty
  a_capture_wait: assert property (p_capture_wait) else $error("strap captured too early");

  // Capture happens as soon as the settled levels agree
  property p_capture_when;
    @(posedge ref_clk) disable iff (sys_rst)
    !st.captured && clk_en && (st.fill_cnt == rsc_pkg::SYNC_FILL) && (st.sync2 == st.sync3) |=> st.captured;
  endproperty
  a_capture_when: assert property (p_capture_when) else $error("strap capture missed");

  // A new selection drops both sources and loads the dead time
  property p_switch_start;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sw_state == rsc_pkg::RSC_SW_IDLE) && (st.mem_sel != st.ext_en) && clk_en
      |=> !st.gen_en && !st.ext_en && (st.gap_cnt == GAP_CYC);
  endproperty
  a_switch_start: assert property (p_switch_start) else $error("clock switch did not start");

  // Both sources stay off for the whole gap
  property p_gap_hold;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sw_state == rsc_pkg::RSC_SW_GAP) |-> !st.gen_en && !st.ext_en;
  endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("source on during gap");

  // The raise step enables exactly the selected source
  property p_raise;
    @(posedge ref_clk) disable iff (sys_rst)
    (st.sw_state == rsc_pkg::RSC_SW_RAISE) && clk_en
      |=> (st.ext_en == $past(st.mem_sel)) && (st.gen_en != $past(st.mem_sel));
  endproperty
  a_raise: assert property (p_raise) else $error("wrong memory clock source raised");

  // Full-rate enable takes the written bit
  property p_full_write;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_strobe && clk_en && (wb_adr_i == rsc_pkg::CLOCK_OUT_CTRL_ADDR) |=> (st.full_en == $past(wb_dat_i[rsc_pkg::FULL_EN_BIT]));
  endproperty
  a_full_write: assert property (p_full_write) else $error("full clock enable not written");

endmodule
`default_nettype wire

//--- src/rsc_pkg.sv
// Purpose: Constants, register map and state types for the strap capture and clock select block
// Assumes: One 125 MHz clock, classic Wishbone register access
// Notes:   Field positions and encodings live here so the logic holds no bare numbers
// Operation
// - Board holds straps steady through reset; device captures them at release.
// - Endian strap must read 1, little endian; 0 is reserved.
// - Boot straps: 00 emulation, 01 8-bit ROM on select one, 10 16-bit.
// - First variant: clock strap 0 bypass x1, 1 PLL x4 default.
// - Second variant: clock strap 1 square-wave source; 0 reserved, keep high.
// - Config bit 4 picks memory clock: 0 generator clock, 1 external pin.
// - First variant: full-rate clock output gated by its enable bit, default on.
// - Half-rate output drives generator half clock; second variant may use GPIO two.
// - Half-rate clock output gated by its enable bit, default on.
// - Second variant: third clock output rate set by oscillator divider one.
// - Second variant: software changes memory clock source through config after reset.
package rsc_pkg;

  // Register byte addresses
  localparam logic [31:0] DEVICE_CONFIG_ADDR  = 32'h019c0200;
  localparam logic [31:0] CLOCK_OUT_CTRL_ADDR = 32'h019c0204;
  localparam logic [31:0] OSC_DIVIDER_ADDR    = 32'h019c0208;
  localparam logic [31:0] STRAP_STATUS_ADDR   = 32'h019c020c;

  // Field positions
  localparam int MEM_CLOCK_SEL_BIT  = 4;
  localparam int FULL_EN_BIT        = 0;
  localparam int HALF_EN_BIT        = 1;
  localparam int HALF_GPIO_BIT      = 2;
  localparam int OSC_RATIO_LSB      = 0;
  localparam int OSC_RATIO_W        = 5;
  localparam int OSC_EN_BIT         = 15;
  localparam int ST_ENDIAN_BIT      = 0;
  localparam int ST_BOOT_LSB        = 1;
  localparam int ST_CLKSTRAP_BIT    = 3;
  localparam int ST_CAPTURED_BIT    = 4;
  localparam int ST_BOOT_RES_BIT    = 5;
  localparam int ST_ENDIAN_RES_BIT  = 6;
  localparam int ST_CLK_RES_BIT     = 7;
  localparam int ST_ACTIVE_SRC_BIT  = 8;

  // Strap encodings and reset values
  localparam logic [1:0] BOOT_EMULATION = 2'h0;
  localparam logic [1:0] BOOT_ROM8      = 2'h1;
  localparam logic [1:0] BOOT_ROM16     = 2'h2;
  localparam logic [1:0] BOOT_RESERVED  = 2'h3;
  localparam logic       ENDIAN_LITTLE  = 1'h1;
  localparam logic       CLK_STRAP_DEF  = 1'h1;
  localparam logic [4:0] OSC_RATIO_RST  = 5'h00;

  // Strap synchroniser depth before the first compare is valid
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // Dead time between dropping one memory clock source and raising the other
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int SWITCH_GAP_NS   = 40;
  localparam int SWITCH_GAP_CYC  = (SWITCH_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {RSC_SW_IDLE, RSC_SW_GAP, RSC_SW_RAISE} rsc_sw_state_t;

  typedef struct packed {
    logic [3:0]    sync1;
    logic [3:0]    sync2;
    logic [3:0]    sync3;
    logic [1:0]    fill_cnt;
    logic          captured;
    logic          endian;
    logic [1:0]    boot;
    logic          clk_strap;
    logic          boot_res;
    logic          core_x4;
    logic          square_src;
    logic          mem_sel;
    logic          full_en;
    logic          half_en;
    logic          half_gpio;
    logic          osc_en;
    logic [4:0]    osc_ratio;
    rsc_sw_state_t sw_state;
    logic [7:0]    gap_cnt;
    logic          gen_en;
    logic          ext_en;
    logic          ack;
    logic [31:0]   rdata;
  } rsc_state_t;

endpackage

//--- verif/rsc_strap_board.sv
// Purpose: Board strap resistors seen by the strap capture block
// Assumes: Levels set by the bench stay put through reset unless wander is raised
// Notes:   Wander toggles every cycle so a stale capture cannot pass by chance
`timescale 1ns/100ps
`default_nettype none
module rsc_strap_board (
  input  wire logic       ref_clk,
  input  wire logic [1:0] boot_level,
  input  wire logic       wander,
  output logic            endian_strap,
  output logic [1:0]      boot_strap,
  output logic            clock_source_strap
);
  logic flip_r = 1'b0;

  // Free toggle used only while the bench asks the pins to move after capture
  always_ff @(posedge ref_clk) begin
    flip_r <= ~flip_r;
  end

  // Resistor levels are static; they hold through the whole reset period
  always_comb begin
    if (wander) begin
      endian_strap       = flip_r;
      boot_strap         = flip_r ? 2'h0 : 2'h2;
      clock_source_strap = flip_r;
    end else begin
      endian_strap       = 1'h1;                                    // Pull-up only, little endian
      boot_strap         = (boot_level == 2'h3) ? 2'h1 : boot_level; // Reserved code never strapped
      clock_source_strap = 1'h1;                                    // Left high, square-wave source
    end
  end
endmodule
`default_nettype wire

//--- verif/rsc_strap_cfg_bench.sv
// Purpose: Self-checking bench for the strap capture and clock select block
// Assumes: Second variant, classic Wishbone answered one cycle after the request edge
// Notes:   Each boot code gets its own reset, so capture is exercised three times
`timescale 1ns/100ps
`default_nettype none
module rsc_strap_cfg_bench;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en  = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, dat_o;
  logic [3:0]  sel = 4'h0;
  logic        ack, end_s, clk_s, capt, end_f, boot_res, x4, sq;
  logic        gen_en, ext_en, full_en, half_en, gpio_m, osc_en;
  logic [1:0]  boot_s, boot_m, boot_lvl = 2'h1;
  logic [4:0]  osc_r;
  logic        wander = 1'b0;
  int          err_count = 0;
  int          cmp_count = 0;

  always #4 ref_clk = ~ref_clk;

  rsc_strap_board i_board (.ref_clk(ref_clk), .boot_level(boot_lvl), .wander(wander),
    .endian_strap(end_s), .boot_strap(boot_s), .clock_source_strap(clk_s));

  rsc_strap_cfg #(.VARIANT(2)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .endian_strap(end_s), .boot_strap(boot_s),
    .clock_source_strap(clk_s), .strap_captured(capt), .endian_field(end_f), .boot_mode(boot_m),
    .boot_reserved(boot_res), .core_clock_x4(x4), .clock_source_square(sq),
    .mem_src_gen_en(gen_en), .mem_src_ext_en(ext_en), .full_clock_out_enable(full_en),
    .half_clock_out_enable(half_en), .half_pin_gpio(gpio_m), .osc_div_enable(osc_en),
    .osc_div_ratio(osc_r));

  // Verdict and end of run
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the wait is bounded so a dead slave cannot hang the run
  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      $display("MISMATCH t=%0t no bus answer", $time);
      conclude();
    end
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, rdat);
    check(rdat, exp);
  endtask

  // Bounded wait for a design output to reach a level, sampled mid-cycle
  task automatic wait_for(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check({31'h0, s}, {31'h0, lvl});
  endtask

  // Both memory clock sources must never be enabled together
  always @(negedge ref_clk) begin
    if (!sys_rst) begin
      check({31'h0, gen_en & ext_en}, 32'h0);
    end
  end

  // Global watchdog in case a wait sneaks past its own bound
  initial begin
    #400000;
    err_count++;
    conclude();
  end

  initial begin
    // Boot codes 00, 01 and 10 each through their own reset; pins then move and the capture must not
    for (int b = 0; b < 3; b++) begin
      boot_lvl <= b[1:0];
      wander   <= 1'b0;
      sys_rst  <= 1'b1;
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      if (b == 1) begin
        // Clock enable low freezes the synchroniser, so nothing may be captured meanwhile
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check({31'h0, capt}, 32'h0);
        clk_en <= 1'b1;
      end
      wait_for(capt, 1'b1);
      @(posedge ref_clk);
      wander <= 1'b1;
      repeat (12) @(negedge ref_clk);
      check({30'h0, boot_m}, {30'h0, b[1:0]});
      check({29'h0, end_f, boot_res, sq}, 32'h5);
      check({31'h0, x4}, 32'h0);
      rd_chk(32'h019c020c, {27'h0, 2'h0, b[1:0], 1'h1} | 32'h18);
    end
    // Reset values of the map and an unmapped place
    rd_chk(32'h019c0200, 32'h0);
    rd_chk(32'h019c0204, 32'h3);
    rd_chk(32'h019c0208, 32'h0);
    rd_chk(32'h019c0300, 32'h0);
    check({30'h0, gen_en, ext_en}, 32'h2);
    // Switch to the external memory clock: dead time first, then the pin source
    wb(1'b1, 32'h019c0200, 32'h10, rdat);
    repeat (2) @(negedge ref_clk);
    check({30'h0, gen_en, ext_en}, 32'h0);
    wait_for(ext_en, 1'b1);
    check({31'h0, gen_en}, 32'h0);
    rd_chk(32'h019c0200, 32'h10);
    rd_chk(32'h019c020c, 32'h11d);
    // Back to the generator clock; the external source must be off once the generator is up
    wb(1'b1, 32'h019c0200, 32'h0, rdat);
    wait_for(gen_en, 1'b1);
    check({31'h0, ext_en}, 32'h0);
    // Clock outputs off, then the half-rate pin handed over to GPIO
    wb(1'b1, 32'h019c0204, 32'h0, rdat);
    @(negedge ref_clk);
    check({29'h0, full_en, half_en, gpio_m}, 32'h0);
    wb(1'b1, 32'h019c0204, 32'h7, rdat);
    @(negedge ref_clk);
    check({29'h0, full_en, half_en, gpio_m}, 32'h7);
    rd_chk(32'h019c0204, 32'h7);
    // Third clock output ratio at its top value with the enable
    wb(1'b1, 32'h019c0208, 32'h801f, rdat);
    @(negedge ref_clk);
    check({26'h0, osc_en, osc_r}, 32'h3f);
    rd_chk(32'h019c0208, 32'h801f);
    // Unmapped write is ignored and the map is unchanged
    wb(1'b1, 32'h019c0300, 32'hffff_ffff, rdat);
    rd_chk(32'h019c0300, 32'h0);
    rd_chk(32'h019c0200, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
